/* qmpc_ctrl.sv */
// Purpose: mode control, pad control and read capture of a quad serial flash controller
// Assumes: pipelined host bus with address and data phases, one word per register
// Notes: serial engine runs manual words and auto reads; pads are registered

// How it works
// [R1] pipe sample delay field sets delay after falling edge, 0 to 7 cycles
// [R2] read pipe enable picks delayed sampling instead of the edge select bit
// [R3] without the pipe, edge bit chooses rising or falling capture
// [R4] manual mode, wait select clear: data register accesses stall until done
// [R5] manual mode, no-wait set: one wait state only, then software polls the busy flag
// [R6] auto mode reads always stall until the data is available
// [R7] io3 and io2 drive values go out when their enables are set
// [R8] io3 enable makes the pad an output; software clears it for quad
// [R9] io2 enable makes the pad an output; software clears it for quad
// [R10] clock mode bit sets the serial clock idle level while deselected
// [R11] mode bit selects manual (0) or auto (1) operation
// [R12] while erasing, writes to the mode select bit are ignored
// [R13] read-only word holds data received by a manual read-data access
// [R14] bits 31:30 set the auto dummy phase width
// [R15] bits 29:28 set the auto extra byte phase width
// [R16] bits 27:26 set the auto address phase width
// [R17] auto mode sends three address bytes, or four with the long address bit
// [R18] reserved width codes run as single-line transfers
module qmpc_ctrl import qmpc_pkg::*; #(
	parameter int HALF_DIV = QMPC_SCK_HALF
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// host bus slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hready_o,
	output logic hresp_o,
	// erase status from the erase logic
	input wire logic erase_in_progress_i,
	// flash pads
	output logic sck_o,
	output logic cs_n_o,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o
);
	logic [QMPC_MODE_W-1:0] mode_r;
	logic [31:0] cmda_r, rx_word_r;
	logic dp_vld_r, dp_wr_r, started_r, eng_rd_r;
	logic [31:0] dp_addr_r, eng_addr_r;
	qmpc_kind_t dp_kind_r, a_kind, eng_kind_r;
	qmpc_state_t st_r;
	logic [31:0] tx_sr_r, rx_sr_r;
	logic [5:0] slots_r, rx_cnt_r, rx_tot;
	qmpc_width_t wid_r, w_adr, w_ext, w_dmy;
	logic drv_r, cap_r, p_r, in_ph, tick, rise_ev, fall_ev;
	logic [7:0] hc_r;
	logic [2:0] lanes, pcd;
	logic [3:0] io_m_r, io_s_r;
	logic [6:0] dl_r;
	logic [7:0] dly_vec;
	logic data_rise, data_fall, cap_stb, eng_acc, start, nowait, quad_own;

	// reserved codes fall back to single line
	function automatic qmpc_width_t wsafe(input logic [1:0] c);
		return (c == 2'h3) ? W_SINGLE : qmpc_width_t'(c); // [R18]
	endfunction

	// phase widths from the command register
	assign w_dmy = wsafe(cmda_r[QMPC_DMY_W_LSB +: 2]); // [R14]
	assign w_ext = wsafe(cmda_r[QMPC_EXT_W_LSB +: 2]); // [R15]
	assign w_adr = wsafe(cmda_r[QMPC_ADR_W_LSB +: 2]); // [R16]
	assign lanes = 3'h1 << wid_r;
	assign pcd = mode_r[QMPC_PCD_LSB +: 3];

	// address phase decode
	always_comb begin
		a_kind = K_REG;
		if (haddr_i[31:26] == QMPC_FLASH_TAG)
			a_kind = K_AUTO;
		else if (haddr_i == QMPC_WDATA_ADDR)
			a_kind = K_WR;
		else if (haddr_i == QMPC_RDATA_ADDR)
			a_kind = K_RD;
		else if (haddr_i == QMPC_DUMMY_ADDR)
			a_kind = K_DMY;
	end

	// data phase tracking
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dp_vld_r <= 1'b0;
			dp_wr_r <= 1'b0;
			dp_addr_r <= 32'h0000_0000;
			dp_kind_r <= K_REG;
		end else if (hready_o) begin
			dp_vld_r <= hsel_i && htrans_i[1] && hready_i;
			dp_wr_r <= hwrite_i;
			dp_addr_r <= haddr_i;
			dp_kind_r <= a_kind;
		end
	end

	// engine accesses: auto reads only in auto mode, data registers only in manual
	always_comb begin
		eng_acc = 1'b0;
		if (dp_vld_r && dp_kind_r != K_REG) begin
			if (dp_kind_r == K_AUTO)
				eng_acc = mode_r[QMPC_AUTO_BIT] && !dp_wr_r; // [R11]
			else
				eng_acc = !mode_r[QMPC_AUTO_BIT]; // [R11]
		end
	end
	assign start = eng_acc && !started_r && st_r == ST_IDLE;
	assign nowait = mode_r[QMPC_NOWAIT_BIT] && dp_kind_r != K_AUTO;

	// wait states: held until done unless manual no-wait is selected
	assign hready_o = !eng_acc || (started_r && (nowait || st_r == ST_DONE)); // [R4] [R5] [R6]
	assign hresp_o = 1'b0;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			started_r <= 1'b0;
		else if (hready_o)
			started_r <= 1'b0;
		else if (start)
			started_r <= 1'b1;
	end

	// register writes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_r <= QMPC_MODE_RST;
			cmda_r <= QMPC_CMDA_RST;
		end else if (dp_vld_r && dp_wr_r && dp_kind_r == K_REG) begin
			if (dp_addr_r == QMPC_MODE_ADDR) begin
				mode_r[QMPC_MODE_W-1:1] <= hwdata_i[QMPC_MODE_W-1:1];
				if (!erase_in_progress_i)
					mode_r[QMPC_AUTO_BIT] <= hwdata_i[QMPC_AUTO_BIT]; // [R12]
			end
			if (dp_addr_r == QMPC_CMDA_ADDR)
				cmda_r <= hwdata_i;
		end
	end

	// read data mux
	always_comb begin
		hrdata_o = 32'h0000_0000;
		if (dp_kind_r == K_AUTO || dp_addr_r == QMPC_RDATA_ADDR)
			hrdata_o = rx_sr_r;
		else if (dp_addr_r == QMPC_MODE_ADDR)
			hrdata_o = {{(32 - QMPC_MODE_W){1'b0}}, mode_r};
		else if (dp_addr_r == QMPC_RECV_ADDR)
			hrdata_o = rx_word_r;
		else if (dp_addr_r == QMPC_CMDA_ADDR)
			hrdata_o = cmda_r;
		else if (dp_addr_r == QMPC_STAT_ADDR)
			hrdata_o = {31'h0000_0000, st_r != ST_IDLE}; // [R5]
	end

	// serial clock half-period timer
	assign in_ph = st_r inside {ST_CMD, ST_ADDR, ST_EXT, ST_DMY, ST_DATA};
	assign tick = in_ph && hc_r == 8'(HALF_DIV - 1);
	assign rise_ev = tick && !p_r;
	assign fall_ev = tick && p_r;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !in_ph) begin
			hc_r <= 8'h00;
			p_r <= 1'b0;
		end else if (tick) begin
			hc_r <= 8'h00;
			p_r <= !p_r;
		end else begin
			hc_r <= hc_r + 8'h01;
		end
	end

	// phase sequencer, one slot per serial clock period
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			tx_sr_r <= 32'h0000_0000;
			slots_r <= 6'h00;
			wid_r <= W_SINGLE;
			drv_r <= 1'b0;
			cap_r <= 1'b0;
			eng_addr_r <= 32'h0000_0000;
			eng_kind_r <= K_REG;
		end else begin
			unique case (st_r)
				ST_IDLE: if (start) begin
					eng_kind_r <= dp_kind_r;
					eng_addr_r <= dp_addr_r;
					wid_r <= W_SINGLE;
					tx_sr_r <= hwdata_i;
					slots_r <= QMPC_WORD_BITS;
					drv_r <= dp_kind_r == K_WR || dp_kind_r == K_AUTO;
					cap_r <= dp_kind_r == K_RD;
					st_r <= ST_DATA;
					if (dp_kind_r == K_AUTO) begin
						st_r <= ST_CMD;
						slots_r <= QMPC_CMD_BITS;
						tx_sr_r <= {cmda_r[QMPC_INST_LSB +: 8], 24'h00_0000};
					end else if (dp_kind_r == K_DMY) begin
						slots_r <= QMPC_DMY_BITS;
					end
				end
				ST_CMD, ST_ADDR, ST_EXT, ST_DMY, ST_DATA: if (fall_ev) begin
					tx_sr_r <= tx_sr_r << lanes;
					slots_r <= slots_r - 6'h01;
					if (slots_r == 6'h01) begin
						unique case (st_r)
							ST_CMD: begin
								st_r <= ST_ADDR;
								wid_r <= w_adr; // [R16]
								if (mode_r[QMPC_A32_BIT]) begin
									slots_r <= QMPC_ADDR4_BITS >> w_adr; // [R17]
									tx_sr_r <= eng_addr_r;
								end else begin
									slots_r <= QMPC_ADDR3_BITS >> w_adr; // [R17]
									tx_sr_r <= {eng_addr_r[23:0], 8'h00};
								end
							end
							ST_ADDR: begin
								st_r <= ST_EXT;
								wid_r <= w_ext; // [R15]
								slots_r <= QMPC_EXT_BITS >> w_ext;
								tx_sr_r <= {cmda_r[QMPC_EXT_LSB +: 8], 24'h00_0000};
							end
							ST_EXT: begin
								st_r <= ST_DMY;
								wid_r <= w_dmy; // [R14]
								slots_r <= QMPC_DMY_BITS >> w_dmy;
								drv_r <= 1'b0;
							end
							ST_DMY: begin
								st_r <= ST_DATA;
								wid_r <= w_adr;
								slots_r <= QMPC_WORD_BITS >> w_adr;
								cap_r <= 1'b1;
							end
							ST_DATA: st_r <= ST_RXW;
						endcase
					end
				end
				ST_RXW: if (rx_cnt_r == rx_tot)
					st_r <= ST_DONE;
				ST_DONE: st_r <= ST_IDLE;
			endcase
		end
	end

	// input synchroniser for the data pads
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			io_m_r <= 4'h0;
			io_s_r <= 4'h0;
		end else begin
			io_m_r <= io_i;
			io_s_r <= io_m_r;
		end
	end

	// capture strobe: edge select or delayed falling edge through the pipe
	assign data_rise = rise_ev && st_r == ST_DATA && cap_r;
	assign data_fall = fall_ev && st_r == ST_DATA && cap_r;
	assign dly_vec = {dl_r, data_fall};
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			dl_r <= 7'h00;
		else
			dl_r <= dly_vec[6:0];
	end
	always_comb begin
		if (mode_r[QMPC_PIPE_BIT])
			cap_stb = dly_vec[pcd]; // [R1] [R2]
		else
			cap_stb = mode_r[QMPC_NEG_BIT] ? data_fall : data_rise; // [R3]
	end
	assign rx_tot = cap_r ? (QMPC_WORD_BITS >> wid_r) : 6'h00;

	// receive shift register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_sr_r <= 32'h0000_0000;
			rx_cnt_r <= 6'h00;
		end else if (st_r == ST_IDLE) begin
			rx_cnt_r <= 6'h00;
		end else if (cap_stb) begin
			rx_cnt_r <= rx_cnt_r + 6'h01;
			unique case (wid_r)
				W_DUAL: rx_sr_r <= {rx_sr_r[29:0], io_s_r[1:0]};
				W_QUAD: rx_sr_r <= {rx_sr_r[27:0], io_s_r};
				default: rx_sr_r <= {rx_sr_r[30:0], io_s_r[1]};
			endcase
		end
	end

	// manual receive word
	assign eng_rd_r = eng_kind_r == K_RD;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			rx_word_r <= QMPC_RECV_RST;
		else if (st_r == ST_DONE && eng_rd_r)
			rx_word_r <= rx_sr_r; // [R13]
	end

	// registered pad drivers
	assign quad_own = in_ph && wid_r == W_QUAD;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sck_o <= 1'b0;
			cs_n_o <= 1'b1;
			io_o <= 4'h0;
			io_oe_o <= 4'h0;
		end else begin
			sck_o <= in_ph ? p_r : mode_r[QMPC_CLK_BIT]; // [R10]
			cs_n_o <= !in_ph;
			io_o[0] <= (wid_r == W_QUAD) ? tx_sr_r[28] :
				(wid_r == W_DUAL) ? tx_sr_r[30] : tx_sr_r[31];
			io_o[1] <= (wid_r == W_QUAD) ? tx_sr_r[29] : tx_sr_r[31];
			io_oe_o[0] <= in_ph && drv_r;
			io_oe_o[1] <= in_ph && drv_r && wid_r != W_SINGLE;
			io_o[2] <= quad_own ? tx_sr_r[30] : mode_r[QMPC_IO2_DAT_BIT]; // [R7]
			io_o[3] <= quad_own ? tx_sr_r[31] : mode_r[QMPC_IO3_DAT_BIT]; // [R7]
			io_oe_o[2] <= quad_own ? drv_r : mode_r[QMPC_IO2_OE_BIT]; // [R9]
			io_oe_o[3] <= quad_own ? drv_r : mode_r[QMPC_IO3_OE_BIT]; // [R8]
		end
	end

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_pipe_fall2;
		mode_r[QMPC_PIPE_BIT] && pcd == 3'h2 && data_fall;
	endsequence
	sequence s_eng_pending;
		eng_acc && started_r && st_r != ST_DONE;
	endsequence

	a_pipe_delay: // [R1] [R2]
		assert property (s_pipe_fall2 |-> ##2 cap_stb) else $error("pipe sample late");
	a_rise_capture: // [R3]
		assert property (!mode_r[QMPC_PIPE_BIT] && !mode_r[QMPC_NEG_BIT] && data_rise
			|-> cap_stb) else $error("rising capture missed");
	a_manual_wait: // [R4]
		assert property (s_eng_pending and !mode_r[QMPC_NOWAIT_BIT] |-> !hready_o)
			else $error("manual access not held");
	a_nowait_ready: // [R5]
		assert property (eng_acc && started_r && dp_kind_r != K_AUTO
			&& mode_r[QMPC_NOWAIT_BIT] |-> hready_o) else $error("no-wait access held");
	a_auto_wait: // [R6]
		assert property (s_eng_pending and dp_kind_r == K_AUTO |-> !hready_o)
			else $error("auto read not held");
	a_io2_drive: // [R7] [R9]
		assert property (!quad_own |=> io_oe_o[2] == $past(mode_r[QMPC_IO2_OE_BIT])
			&& io_o[2] == $past(mode_r[QMPC_IO2_DAT_BIT])) else $error("io2 pad wrong");
	a_io3_drive: // [R7] [R8]
		assert property (!quad_own |=> io_oe_o[3] == $past(mode_r[QMPC_IO3_OE_BIT])
			&& io_o[3] == $past(mode_r[QMPC_IO3_DAT_BIT])) else $error("io3 pad wrong");
	a_idle_clock: // [R10]
		assert property (cs_n_o |-> sck_o == $past(mode_r[QMPC_CLK_BIT]))
			else $error("serial clock idle level wrong");
	a_auto_only: // [R11]
		assert property (st_r == ST_CMD |-> mode_r[QMPC_AUTO_BIT] || eng_kind_r == K_AUTO)
			else $error("auto sequence outside auto mode");
	a_erase_lock: // [R12]
		assert property (erase_in_progress_i |=> $stable(mode_r[QMPC_AUTO_BIT]))
			else $error("mode bit changed during erase");
	a_rx_word: // [R13]
		assert property (st_r == ST_DONE && eng_rd_r |=> rx_word_r == $past(rx_sr_r))
			else $error("receive word not updated");
	a_addr_bytes: // [R17]
		assert property (st_r == ST_CMD && fall_ev && slots_r == 6'h01 ##1 1 |->
			(slots_r << wid_r) == (mode_r[QMPC_A32_BIT] ? 6'h20 : 6'h18))
			else $error("address length wrong");
	a_no_reserved: // [R18]
		assert property (in_ph |-> wid_r != W_RSVD) else $error("reserved width used");
endmodule

/* qmpc_ctrl_bench.sv */
// Purpose: register-level bench for the flash mode and phase controller
// Assumes: half period divider 4, flash model on the pads
// Notes: bus tasks look at ready at the falling clock edge, settled
module qmpc_ctrl_bench import qmpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic hready_i = 1'b1;
	logic erase_in_progress_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic hready_o;
	logic hresp_o;
	logic sck_o;
	logic cs_n_o;
	logic [3:0] io_i;
	logic [3:0] io_o;
	logic [3:0] io_oe_o;
	logic [3:0] fl_io;
	logic [31:0] fl_word = 32'h0;
	logic [31:0] head;
	logic [6:0] fl_skip = 7'h0;
	logic [31:0] rd;
	logic [31:0] mv;
	logic [31:0] msk;
	int waits;
	int mismatches = 0;
	int comparisons = 0;
	// clock
	always #2 sys_clk_i = ~sys_clk_i;
	// pad level from whoever drives it
	assign io_i = (io_oe_o & io_o) | (~io_oe_o & fl_io);
	qmpc_ctrl #(.HALF_DIV(4)) i_dut (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hready_o, .hresp_o, .erase_in_progress_i,
		.sck_o, .cs_n_o, .io_i, .io_o, .io_oe_o);
	qmpc_flash_model i_flash (.clk_i(sys_clk_i), .sck_i(sck_o), .cs_n_i(cs_n_o), .io_i(io_i),
		.word_i(fl_word), .skip_i(fl_skip), .head_o(head), .io_o(fl_io));
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one bus access, entered just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		haddr_i <= a;
		hwrite_i <= wr;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		@(posedge sys_clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		waits = 0;
		@(negedge sys_clk_i);
		while (hready_o !== 1'b1 && waits < 5000) begin
			waits++;
			@(negedge sys_clk_i);
		end
		rd = hrdata_o;
		@(posedge sys_clk_i);
	endtask
	// verdict
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (50000) @(posedge sys_clk_i);
		mismatches++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		bus(0, QMPC_MODE_ADDR, 0); check(rd, 32'h0);
		bus(0, QMPC_RECV_ADDR, 0); check(rd, 32'h0);
		bus(0, QMPC_CMDA_ADDR, 0); check(rd, 32'h0);
		bus(0, 32'h0C00_0040, 0); check(rd, 32'h0);
		$display("reset values done");
		// pad drive and clock idle level
		for (int i = 0; i < 3; i++) begin
			mv = (i == 0) ? 32'hFFFF_FFFE : (i == 1) ? 32'h0000_0014 : 32'h0000_0028;
			bus(1, QMPC_MODE_ADDR, mv);
			bus(0, QMPC_MODE_ADDR, 0); check(rd, mv & 32'h0000_3FFF);
			repeat (2) @(posedge sys_clk_i);
			@(negedge sys_clk_i);
			check({30'h0, io_oe_o[3:2]}, {30'h0, mv[3:2]});
			check({30'h0, io_o[3:2] & io_oe_o[3:2]}, {30'h0, mv[5:4] & mv[3:2]});
			check({30'h0, cs_n_o, sck_o}, {30'h0, 1'b1, mv[1]});
			@(posedge sys_clk_i);
		end
		$display("pad control done");
		// mode bit locked while erasing
		erase_in_progress_i <= 1'b1;
		bus(1, QMPC_MODE_ADDR, 32'h3);
		bus(0, QMPC_MODE_ADDR, 0); check(rd, 32'h2);
		erase_in_progress_i <= 1'b0;
		bus(1, QMPC_MODE_ADDR, 32'h3);
		bus(0, QMPC_MODE_ADDR, 0); check(rd, 32'h3);
		bus(1, QMPC_CMDA_ADDR, 32'h6C5A_00A5);
		bus(0, QMPC_CMDA_ADDR, 0); check(rd, 32'h6C5A_00A5);
		$display("mode and widths done");
		// manual reads with rising, falling, pipe delay 0 and pipe delay 2 capture, wait states on
		for (int i = 0; i < 4; i++) begin
			mv = (i == 0) ? 32'h0 : (i == 1) ? 32'h80 : (i == 2) ? 32'h100 : 32'h500;
			fl_word <= 32'hC3A5_0F96 ^ {8'h0, 24'(i * 32'h1111)};
			bus(1, QMPC_MODE_ADDR, mv);
			bus(0, QMPC_RDATA_ADDR, 0);
			check(rd, 32'hC3A5_0F96 ^ {8'h0, 24'(i * 32'h1111)});
			check({31'h0, waits > 100}, 32'h1);
		end
		bus(1, QMPC_WDATA_ADDR, 32'h5A3C_96E1);
		check(head, 32'h5A3C_96E1);
		// dummy clocks also hold the bus for their eight slots
		bus(1, QMPC_DUMMY_ADDR, 32'h0);
		check({31'h0, waits > 50 && waits < 100}, 32'h1);
		check({31'h0, hresp_o}, 32'h0);
		$display("manual wait transfers done");
		// manual read with a single wait state, polled
		fl_word <= 32'h1E2D_3C4B;
		bus(1, QMPC_MODE_ADDR, 32'h40);
		bus(0, QMPC_RDATA_ADDR, 0);
		check(waits, 1);
		bus(0, QMPC_STAT_ADDR, 0);
		check({31'h0, rd[0]}, 32'h1);
		for (int n = 0; n < 200 && rd[0] !== 1'b0; n++) bus(0, QMPC_STAT_ADDR, 0);
		bus(0, QMPC_RECV_ADDR, 0); check(rd, 32'h1E2D_3C4B);
		$display("manual polled read done");
		// auto reads, reserved widths, both address lengths, no-wait set
		for (int j = 0; j < 2; j++) begin
			bus(1, QMPC_MODE_ADDR, 32'h0);
			bus(1, QMPC_CMDA_ADDR, 32'hFC00_00A5);
			fl_skip <= (j == 1) ? 7'd56 : 7'd48;
			fl_word <= 32'h8421_7BDE + 32'(j);
			bus(1, QMPC_MODE_ADDR, (j == 1) ? 32'h2041 : 32'h41);
			bus(0, {6'h02, 26'h001_2345}, 0);
			check(rd, 32'h8421_7BDE + 32'(j));
			check({31'h0, waits > 1}, 32'h1);
			msk = (j == 1) ? 32'hFF00_0000 : 32'hFFFF_FFFF;
			check(head & msk, 32'hA501_2345 & msk);
		end
		$display("auto reads done");
		summarize();
	end
endmodule

/* qmpc_flash_model.sv */
// Purpose: serial flash stand-in for the mode and phase controller bench
// Assumes: mode 0 traffic, single-line transfers
// Notes: released lines change every cycle so a stale bit never passes for data
module qmpc_flash_model (
	// clock and link pins
	input wire logic clk_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	// word to return and serial bits to let pass first
	input wire logic [31:0] word_i,
	input wire logic [6:0] skip_i,
	// first word seen on io0, lines toward the pads
	output logic [31:0] head_o,
	output logic [3:0] io_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	int nf = 0;
	int nr = 0;
	int k;
	// pattern for every released line
	always @(posedge clk_i) tog <= ~tog;
	// bit counts restart with each selection
	always @(negedge cs_n_i) begin
		nf = 0;
		nr = 0;
	end
	// output moves on at the falling serial edge
	always @(negedge sck_i) if (!cs_n_i) nf = nf + 1;
	// input taken at the rising serial edge, msb first
	always @(posedge sck_i) begin
		if (!cs_n_i && nr < 32) begin
			head_o = {head_o[30:0], io_i[0]};
			nr = nr + 1;
		end
	end
	// data on io1 only inside the frame and inside the word
	assign k = nf - int'(skip_i);
	assign io_o[1] = (!cs_n_i && k >= 0 && k < 32) ? word_i[31 - k] : tog;
	assign io_o[0] = ~tog;
	assign io_o[3:2] = {tog, ~tog};
endmodule

/* qmpc_pkg.sv */
// Purpose: constants and types for the flash mode and phase controller
// Assumes: 32-bit host bus, registers at their full byte addresses
// Notes: width codes follow the phase-width field encoding
package qmpc_pkg;
	// register byte addresses
	localparam logic [31:0] QMPC_MODE_ADDR = 32'h0C00_0004;
	localparam logic [31:0] QMPC_RECV_ADDR = 32'h0C00_0008;
	localparam logic [31:0] QMPC_CMDA_ADDR = 32'h0C00_000C;
	localparam logic [31:0] QMPC_STAT_ADDR = 32'h0C00_0014;
	localparam logic [31:0] QMPC_WDATA_ADDR = 32'h0C00_0018;
	localparam logic [31:0] QMPC_RDATA_ADDR = 32'h0C00_001C;
	localparam logic [31:0] QMPC_DUMMY_ADDR = 32'h0C00_0020;
	// flash read window, tag in address bits 31:26
	localparam logic [5:0] QMPC_FLASH_TAG = 6'h02;
	// mode_control field positions
	localparam int QMPC_AUTO_BIT = 0;
	localparam int QMPC_CLK_BIT = 1;
	localparam int QMPC_IO2_OE_BIT = 2;
	localparam int QMPC_IO3_OE_BIT = 3;
	localparam int QMPC_IO2_DAT_BIT = 4;
	localparam int QMPC_IO3_DAT_BIT = 5;
	localparam int QMPC_NOWAIT_BIT = 6;
	localparam int QMPC_NEG_BIT = 7;
	localparam int QMPC_PIPE_BIT = 8;
	localparam int QMPC_PCD_LSB = 9;
	localparam int QMPC_A32_BIT = 13;
	localparam int QMPC_MODE_W = 14;
	// auto_read_command_a field positions
	localparam int QMPC_INST_LSB = 0;
	localparam int QMPC_EXT_LSB = 16;
	localparam int QMPC_ADR_W_LSB = 26;
	localparam int QMPC_EXT_W_LSB = 28;
	localparam int QMPC_DMY_W_LSB = 30;
	// reset values
	localparam logic [13:0] QMPC_MODE_RST = 14'h0000;
	localparam logic [31:0] QMPC_CMDA_RST = 32'h0000_0000;
	localparam logic [31:0] QMPC_RECV_RST = 32'h0000_0000;
	// phase lengths in bits and serial clock half period
	localparam logic [5:0] QMPC_CMD_BITS = 6'h08;
	localparam logic [5:0] QMPC_ADDR3_BITS = 6'h18;
	localparam logic [5:0] QMPC_ADDR4_BITS = 6'h20;
	localparam logic [5:0] QMPC_EXT_BITS = 6'h08;
	localparam logic [5:0] QMPC_DMY_BITS = 6'h08;
	localparam logic [5:0] QMPC_WORD_BITS = 6'h20;
	localparam int QMPC_SCK_HALF = 4;
	typedef enum logic [1:0] {W_SINGLE, W_DUAL, W_QUAD, W_RSVD} qmpc_width_t;
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_EXT, ST_DMY, ST_DATA, ST_RXW,
		ST_DONE} qmpc_state_t;
	typedef enum logic [2:0] {K_REG, K_WR, K_RD, K_DMY, K_AUTO} qmpc_kind_t;
endpackage
